//--- hw/asc_defs.svh
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// clock period in ns
`define ASC_CLK_PERIOD_NS 50
// memory shape
`define ASC_ADDR_W 12
`define ASC_DATA_W 4
`define ASC_DEPTH 4096
// read cycle time and write pulse width in ns (slowest grade)
`define ASC_T_RC_NS 25
`define ASC_T_WP_NS 20
// address setup before strobe and hold after, ns
`define ASC_T_AS_NS 0
`define ASC_T_AH_NS 0
// cycle counts, least times rounded up, never below one
`define ASC_RD_CYC ((`ASC_T_RC_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_WP_CYC ((`ASC_T_WP_NS + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_SETUP_CYC 1
`define ASC_HOLD_CYC 1
// extra strobe cycles so the read word crosses the two-flop synchroniser
`define ASC_SYNC_CYC 2
`define ASC_CNT_W 4
`endif

//--- hw/asc_pkg.sv
package asc_pkg;
    // request from the user side
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [3:0] wdata;
    } asc_req_t;
    // levels driven toward the memory pins
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic [11:0] addr;
        logic [3:0] dout;
        logic doe;
    } asc_pins_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RETAIN
    } asc_state_t;
endpackage

//--- hw/asc_sync.sv
`timescale 1ns/100ps
// two flip-flop synchroniser per bit
module asc_sync #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    // first stage read only by the second
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule

//--- hw/asc_ctrl.sv
`timescale 1ns/100ps
`include "asc_defs.svh"
// Notes on behaviour
// - writes happen only while select and write strobe are both low, data driven meanwhile
// - reads keep write strobe high and select low; memory drives the word
// - write starts on the later falling strobe, ends on the first rising one
// - address is valid no later than select going low on reads
// - before low supply retention, select is held high; no delay needed
module asc_ctrl #(
    parameter int ADDR_W = `ASC_ADDR_W,
    parameter int DATA_W = `ASC_DATA_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic req_we_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [DATA_W-1:0] req_wdata_i,
    output logic req_ready_o,
    output logic [DATA_W-1:0] rd_data_o,
    output logic rd_valid_o,
    output logic wr_done_o,
    input wire logic retain_req_i,
    output logic retain_ok_o,
    output logic mem_cs_n_o,
    output logic mem_we_n_o,
    output logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [DATA_W-1:0] mem_data_i,
    output logic [DATA_W-1:0] mem_data_o,
    output logic [DATA_W-1:0] mem_data_oe_o
);
    localparam logic [3:0] SETUP_C = 4'(`ASC_SETUP_CYC);
    // read strobe spans the access time plus the synchroniser latency
    localparam logic [3:0] RD_C = 4'(`ASC_RD_CYC + `ASC_SYNC_CYC);
    localparam logic [3:0] WP_C = 4'(`ASC_WP_CYC);
    localparam logic [3:0] HOLD_C = 4'(`ASC_HOLD_CYC);

    asc_pkg::asc_state_t state_r;
    asc_pkg::asc_state_t state_nxt;
    asc_pkg::asc_req_t req_r;
    asc_pkg::asc_req_t req_nxt;
    asc_pkg::asc_pins_t pins_r;
    asc_pkg::asc_pins_t pins_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic wr_done_r;
    logic wr_done_nxt;
    logic [DATA_W-1:0] din_s;
    logic take_s;
    logic strobe_end_s;

    // pin inputs pass two flops before use
    asc_sync #(.W(DATA_W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(mem_data_i),
        .q_o(din_s)
    );

    // request accepted on this edge
    assign take_s = (state_r == asc_pkg::ST_IDLE) && !retain_req_i && req_valid_i;
    // last cycle of the strobe phase
    assign strobe_end_s = (state_r == asc_pkg::ST_STROBE) && (cnt_r <= 4'h1);

    // access sequencer
    always_comb begin
        state_nxt = state_r;
        pins_nxt = pins_r;
        cnt_nxt = cnt_r;
        case (state_r)
            // idle: deselected, waiting for work
            asc_pkg::ST_IDLE: begin
                pins_nxt.cs_n = 1'b1; // deselected means standby
                pins_nxt.we_n = 1'b1;
                pins_nxt.doe = 1'b0; // float when not writing
                if (retain_req_i) begin
                    state_nxt = asc_pkg::ST_RETAIN; // select already high
                end else if (req_valid_i) begin
                    pins_nxt.addr = req_addr_i; // address before select
                    cnt_nxt = SETUP_C;
                    state_nxt = asc_pkg::ST_SETUP;
                end
            end
            // setup: address settles before select falls
            asc_pkg::ST_SETUP: begin
                if (cnt_r <= 4'h1) begin
                    pins_nxt.cs_n = 1'b0; // select low
                    if (req_r.we) begin
                        pins_nxt.we_n = 1'b0; // both low opens write
                        pins_nxt.dout = req_r.wdata;
                        pins_nxt.doe = 1'b1;
                        cnt_nxt = WP_C;
                    end else begin
                        cnt_nxt = RD_C; // covers access time plus sync delay
                    end
                    state_nxt = asc_pkg::ST_STROBE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            // strobe: select low for the access
            asc_pkg::ST_STROBE: begin
                if (cnt_r <= 4'h1) begin
                    pins_nxt.we_n = 1'b1; // first rising strobe ends write
                    pins_nxt.cs_n = 1'b1;
                    cnt_nxt = HOLD_C;
                    state_nxt = asc_pkg::ST_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            // hold: data and address outlast the strobe
            asc_pkg::ST_HOLD: begin
                // data and address held one cycle past strobe
                if (cnt_r <= 4'h1) begin
                    pins_nxt.doe = 1'b0; // release bus
                    state_nxt = asc_pkg::ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            // retention: kept deselected until released
            asc_pkg::ST_RETAIN: begin
                pins_nxt.cs_n = 1'b1; // held deselected
                pins_nxt.doe = 1'b0;
                if (!retain_req_i) begin
                    state_nxt = asc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = asc_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= asc_pkg::ST_IDLE;
            pins_r.cs_n <= 1'b1;
            pins_r.we_n <= 1'b1;
            pins_r.addr <= '0;
            pins_r.dout <= '0;
            pins_r.doe <= 1'b0;
            cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // request latch, loaded on the accepting edge
    always_comb begin
        req_nxt = req_r;
        if (take_s) begin
            req_nxt.we = req_we_i;
            req_nxt.addr = req_addr_i;
            req_nxt.wdata = req_wdata_i;
        end
    end

    // request registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_r <= '0;
        end else begin
            req_r <= req_nxt;
        end
    end

    // completion pulses and read word
    always_comb begin
        rdata_nxt = rdata_r;
        rd_valid_nxt = 1'b0;
        wr_done_nxt = 1'b0;
        if (strobe_end_s) begin
            if (req_r.we) begin
                wr_done_nxt = 1'b1;
            end else begin
                rdata_nxt = din_s; // word driven by memory
                rd_valid_nxt = 1'b1;
            end
        end
    end

    // completion registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= '0;
            rd_valid_r <= 1'b0;
            wr_done_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rd_valid_r <= rd_valid_nxt;
            wr_done_r <= wr_done_nxt;
        end
    end

    // per bit data drivers, enable high while driving
    for (genvar i = 0; i < DATA_W; i++) begin : g_dq
        assign mem_data_o[i] = pins_r.dout[i];
        assign mem_data_oe_o[i] = pins_r.doe;
    end

    // outputs
    assign req_ready_o = (state_r == asc_pkg::ST_IDLE) && !retain_req_i;
    assign retain_ok_o = (state_r == asc_pkg::ST_RETAIN);
    assign rd_data_o = rdata_r;
    assign rd_valid_o = rd_valid_r;
    assign wr_done_o = wr_done_r;
    assign mem_cs_n_o = pins_r.cs_n;
    assign mem_we_n_o = pins_r.we_n;
    assign mem_addr_o = pins_r.addr; // 12 lines, 4096 words
endmodule

//--- verification/asc_ctrl_asserts.sv
`timescale 1ns/100ps
// pin-level checks on the controller side of the memory
module asc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_valid_o,
    input wire logic wr_done_o,
    input wire logic retain_ok_o,
    input wire logic mem_cs_n_o,
    input wire logic mem_we_n_o,
    input wire logic [11:0] mem_addr_o,
    input wire logic [3:0] mem_data_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wr_drive_a: assert property (!mem_we_n_o |-> !mem_cs_n_o && mem_data_oe_o == 4'hf) else $error("bad write");
    read_seq_a: assert property ($fell(mem_cs_n_o) && mem_we_n_o |=> !mem_cs_n_o && mem_we_n_o ##1 !mem_cs_n_o
        ##1 mem_cs_n_o && rd_valid_o)
        else $error("bad read");
    wr_pulse_a: assert property ($fell(mem_we_n_o) |-> $fell(mem_cs_n_o) ##1 mem_cs_n_o && mem_we_n_o && wr_done_o)
        else $error("bad pulse");
    addr_early_a: assert property (mem_cs_n_o ##1 !mem_cs_n_o |-> $stable(mem_addr_o)) else $error("late addr");
    retain_desel_a: assert property (retain_ok_o |-> mem_cs_n_o && $past(mem_cs_n_o)) else $error("selected");
    bus_free_a: assert property (mem_data_oe_o != 4'h0 |-> !mem_we_n_o || $past(!mem_we_n_o)) else $error("contention");
    addr_hold_a: assert property (!mem_cs_n_o |=> $stable(mem_addr_o)) else $error("addr moved");
    // main scenarios
    cover property ($fell(mem_we_n_o));
    cover property (rd_valid_o);
    cover property (retain_ok_o);
endmodule
bind asc_ctrl asc_chk chk (.clk_i, .rst_i, .rd_valid_o, .wr_done_o, .retain_ok_o, .mem_cs_n_o, .mem_we_n_o,
    .mem_addr_o, .mem_data_oe_o);

//--- verification/asc_sram_model.sv
`timescale 1ns/100ps
// behavioural 4k x 4 static memory
module asc_sram_model (
    input wire logic cs_n_i,
    input wire logic we_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [3:0] d_i,
    output logic [3:0] q_o
);
    logic [3:0] mem [4096];
    logic [3:0] last = 4'h0;
    // write while both strobes low; a read drives the word, otherwise the inverted last read word is driven
    always @(cs_n_i or we_n_i or addr_i or d_i) begin
        if (!cs_n_i && !we_n_i) mem[addr_i] = d_i;
        if (!cs_n_i && we_n_i) last = mem[addr_i];
        q_o = (!cs_n_i && we_n_i) ? mem[addr_i] : ~last;
    end
endmodule

//--- verification/test_async_sram_4k_by_4.sv
`timescale 1ns/100ps
module test_async_sram_4k_by_4;
    logic clk_i = 0, rst_i = 1, req_valid_i = 0, req_we_i = 0, retain_req_i = 0;
    logic [11:0] req_addr_i = 12'h000, mem_addr_o;
    logic [3:0] req_wdata_i = 4'h0, rd_data_o, mem_data_o, mem_data_oe_o, q, bus;
    logic req_ready_o, rd_valid_o, wr_done_o, retain_ok_o, mem_cs_n_o, mem_we_n_o;
    logic [15:0] lfsr = 16'h2c31;
    logic [3:0] shadow [4096];
    logic [11:0] used [$];
    int errors = 0, n_compared = 0;
    // resolved data bus
    assign bus = (mem_data_oe_o & mem_data_o) | (~mem_data_oe_o & q);
    asc_ctrl dut (.clk_i, .rst_i, .req_valid_i, .req_we_i, .req_addr_i, .req_wdata_i, .req_ready_o, .rd_data_o,
        .rd_valid_o, .wr_done_o, .retain_req_i, .retain_ok_o, .mem_cs_n_o, .mem_we_n_o, .mem_addr_o,
        .mem_data_i(bus), .mem_data_o, .mem_data_oe_o);
    asc_sram_model mem_m (.cs_n_i(mem_cs_n_o), .we_n_i(mem_we_n_o), .addr_i(mem_addr_o), .d_i(bus), .q_o(q));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input logic [3:0] got, input logic [3:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one request, waits for its completion pulse
    task automatic access(input logic we, input logic [11:0] a, input logic [3:0] d);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 20) begin
            errors++;
            $display("[FAIL] %0t never ready", $time);
            report_and_stop();
        end
        req_valid_i = 1;
        req_we_i = we;
        req_addr_i = a;
        req_wdata_i = d;
        @(negedge clk_i);
        req_valid_i = 0;
        n = 0;
        while ((we ? wr_done_o : rd_valid_o) !== 1'b1 && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 20) begin
            errors++;
            $display("[FAIL] %0t no completion", $time);
            report_and_stop();
        end
        if (we) shadow[a] = d;
        else check(rd_data_o, shadow[a], "read data");
    endtask
    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 0;
        access(1'b1, 12'h000, 4'ha);
        access(1'b1, 12'hfff, 4'h5);
        access(1'b0, 12'hfff, 4'h0);
        access(1'b0, 12'h000, 4'h0);
        for (int i = 0; i < 60; i++) begin
            lfsr = step(lfsr);
            access(1'b1, lfsr[11:0], lfsr[15:12]);
            used.push_back(lfsr[11:0]);
        end
        // deselected retention refuses requests
        retain_req_i = 1;
        repeat (3) @(negedge clk_i);
        check({retain_ok_o, mem_cs_n_o, req_ready_o, 1'b0}, 4'hc, "retention");
        retain_req_i = 0;
        foreach (used[i]) access(1'b0, used[i], 4'h0);
        report_and_stop();
    end
endmodule
